// >>> frs_defs.svh
/*
 Constants of the flash/rtc/software reset-source block: register offsets,
 bit positions, reset values and timing counts.
 Assumes inclusion by bare name from the package and the modules.
*/
`ifndef FRS_DEFS_SVH
`define FRS_DEFS_SVH
`define FRS_OFF_SRC 12'h000
`define FRS_OFF_CTRL 12'h004
`define FRS_OFF_IRQ_STAT 12'h008
`define FRS_OFF_IRQ_MASK 12'h00C
`define FRS_OFF_LOCK 12'h010
`define FRS_BIT_SWRF 4
`define FRS_BIT_RTC 5
`define FRS_BIT_FERR 6
`define FRS_BIT_RTCEN 7
`define FRS_CTRL_MCD 0
`define FRS_CTRL_ALM 1
`define FRS_ZERO32 32'h0000_0000
`define FRS_LOCK_RST 17'h1_FBFF
`define FRS_RST_CYCLES 16
`define FRS_SYNC_STAGES 2
`define FRS_OSC_MIN_HZ 20000
`define FRS_CLK_HZ 50000000
`endif

// >>> frs_pkg.sv
/*
 Types shared by the reset-source block.
 Assumes frs_defs.svh is on the include path.
*/
`include "frs_defs.svh"
package frs_pkg;
    // Cause of the most recent internal reset
    typedef enum logic [1:0] {
        FRS_CAUSE_NONE = 2'h0,
        FRS_CAUSE_FLASH = 2'h1,
        FRS_CAUSE_RTC = 2'h3,
        FRS_CAUSE_SW = 2'h2
    } frs_cause_t;
    // Pulse stretcher states, Gray ordered
    typedef enum logic [1:0] {
        FRS_IDLE = 2'b00,
        FRS_HOLD = 2'b01,
        FRS_DONE = 2'b11
    } frs_state_t;
endpackage

// >>> frs_sync.sv
/*
 Two-flop level synchroniser for event requests.
 Assumes the input may be asynchronous to pclk.
*/
`timescale 1ns/1ns
`include "frs_defs.svh"
module frs_sync #(
    parameter int WIDTH = 2
) (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic [WIDTH-1:0] d_in, // Raw levels
    output logic [WIDTH-1:0] d_out // Synchronised levels
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s1_nxt;
    logic [WIDTH-1:0] s2_nxt;
    // First stage feeds only the second
    always_comb begin
        s1_nxt = d_in;
        s2_nxt = s1_r;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= '0;
            d_out <= '0;
        end else begin
            s1_r <= s1_nxt;
            d_out <= s2_nxt;
        end
    end
endmodule

// >>> frs_stretch.sv
/*
 Stretches a one-cycle reset trigger to a fixed hold of CYCLES clocks.
 Assumes the trigger is synchronous to pclk.
*/
`timescale 1ns/1ns
`include "frs_defs.svh"
module frs_stretch #(
    parameter int CYCLES = `FRS_RST_CYCLES
) (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic trig, // Reset trigger pulse
    output logic rst_out // Held internal reset, active high
);
    frs_pkg::frs_state_t st_r;
    frs_pkg::frs_state_t st_nxt;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic rst_nxt;
    // Hold counts down; a new trigger during hold restarts it
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        case (st_r)
            frs_pkg::FRS_IDLE: begin
                if (trig) begin
                    st_nxt = frs_pkg::FRS_HOLD;
                    cnt_nxt = 8'(CYCLES - 1);
                end
            end
            frs_pkg::FRS_HOLD: begin
                if (trig) begin
                    cnt_nxt = 8'(CYCLES - 1);
                end else if (cnt_r == 8'h00) begin
                    st_nxt = frs_pkg::FRS_DONE;
                end else begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
            // A trigger in the closing cycle starts a fresh hold, or it would be lost
            frs_pkg::FRS_DONE: begin
                if (trig) begin
                    st_nxt = frs_pkg::FRS_HOLD;
                    cnt_nxt = 8'(CYCLES - 1);
                end else begin
                    st_nxt = frs_pkg::FRS_IDLE;
                end
            end
            default: begin
                st_nxt = frs_pkg::FRS_IDLE;
            end
        endcase
        rst_nxt = (st_nxt == frs_pkg::FRS_HOLD);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= frs_pkg::FRS_IDLE;
            cnt_r <= 8'h00;
            rst_out <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            rst_out <= rst_nxt; // [R16]
        end
    end
endmodule

// >>> frs_top.sv
/*
 Reset-source block: flash error, real-time-clock and software reset
 causes, cause flags, interrupt status/mask, APB register slave.
 Assumes the flash controller, CPU and rtc present single-cycle or level
 request inputs, and that sys_rst_out is ORed into the chip reset tree
 without touching the external reset pin. pclk/presetn must stay alive
 in low-power modes, since the rtc path depends on them.
*/
// Overview of operation
// R01: Illegal flash read, write, erase or fetch address raises a full system reset; the erase strobe address is not compared with the lock.
// R02: Write enable set and data-move write above lock address causes flash reset.
// R03: Code-memory read above lock address causes flash error reset.
// R04: Branch fetch above lock address causes flash error reset.
// R05: Access forbidden by flash security settings causes flash error reset.
// R06: Flash write or erase with supply monitor off causes flash error reset.
// R07: Flash error flag, bit 6 of source register, reads set afterward.
// R08: These resets act internally only; external reset pin untouched.
// R09: Rtc may request reset on oscillator failure or alarm match.
// R10: Oscillator failure counts when missing clock detector is enabled and clock slow.
// R11: Alarm counts when alarm enabled and timer equals alarm match registers.
// R12: Rtc events reset only when rtc reset enable, bit 7, is one.
// R13: Rtc reset path stays working in Suspend and Sleep modes.
// R14: Writing one to software reset force, bit 4, forces reset at once.
// R15: Software reset force bit reads one after a software reset.
// R16: Rtc requests are synchronised; each request is held a fixed minimum cycle count.
// R17: A new reset clears other cause flags; exactly one cause reads set.
`timescale 1ns/1ns
`include "frs_defs.svh"
module frs_top #(
    parameter int ADDR_W = 17,
    parameter int RTC_W = 32,
    parameter int HOLD_CYCLES = `FRS_RST_CYCLES
) (
    input wire logic pclk, // System clock, 50 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic flash_write_enable, // Flash program enable bit
    input wire logic external_data_move, // Data-move write strobe
    input wire logic code_memory_read, // Code-memory read strobe
    input wire logic fetch_strobe, // Instruction fetch strobe
    input wire logic erase_strobe, // Flash erase strobe
    input wire logic [ADDR_W-1:0] flash_addr, // Target address of the strobe
    input wire logic security_block, // Flash security forbids this access
    input wire logic vdd_monitor_en, // Supply monitor enabled
    input wire logic rtc_osc_slow, // Rtc clock below about 20 kHz
    input wire logic [RTC_W-1:0] rtc_timer, // Rtc timer value
    input wire logic [RTC_W-1:0] alarm_match_registers, // Alarm compare value
    output logic sys_rst_out, // Internal system reset, active high
    output logic irq // Level interrupt
);
    logic [1:0] rtc_raw;
    logic [1:0] rtc_sync;
    logic osc_fail_ev;
    logic alarm_ev;
    logic flash_err_ev;
    logic wr_any;
    logic rtc_ev;
    logic trig;
    logic apb_wr;
    logic apb_rd;
    logic mapped;
    logic [ADDR_W-1:0] lock_r;
    logic [ADDR_W-1:0] lock_nxt;
    logic rtcen_r;
    logic rtcen_nxt;
    logic [1:0] ctrl_r;
    logic [1:0] ctrl_nxt;
    frs_pkg::frs_cause_t cause_r;
    frs_pkg::frs_cause_t cause_nxt;
    logic [2:0] ist_r;
    logic [2:0] ist_nxt;
    logic [2:0] imask_r;
    logic [2:0] imask_nxt;
    logic [31:0] rd_nxt;
    logic err_nxt;
    logic rtc_prev_r;
    logic rtc_prev_nxt;

    // Oscillator flag and alarm compare, qualified by their enables
    always_comb begin
        rtc_raw[0] = ctrl_r[`FRS_CTRL_MCD] & rtc_osc_slow; // [R10]
        rtc_raw[1] = ctrl_r[`FRS_CTRL_ALM] & (rtc_timer == alarm_match_registers); // [R11]
    end

    // Rtc side may be slow or asynchronous, so its levels are synchronised
    frs_sync #(
        .WIDTH(2)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d_in(rtc_raw),
        .d_out(rtc_sync)
    );

    // Event detection; sync logic has no low-power gating
    always_comb begin
        osc_fail_ev = rtc_sync[0]; // [R09] [R13]
        alarm_ev = rtc_sync[1]; // [R09]
        wr_any = (flash_write_enable & external_data_move) | erase_strobe;
        flash_err_ev = ((flash_write_enable & external_data_move & (flash_addr > lock_r)) // [R02]
            | (code_memory_read & (flash_addr > lock_r)) // [R03]
            | (fetch_strobe & (flash_addr > lock_r)) // [R04]
            | ((code_memory_read | fetch_strobe | wr_any) & security_block) // [R05]
            | (wr_any & ~vdd_monitor_en)); // [R06]
        rtc_ev = rtcen_r & (osc_fail_ev | alarm_ev); // [R12]
        apb_wr = psel & penable & pwrite;
        apb_rd = psel & penable & ~pwrite;
        trig = flash_err_ev | (rtc_ev & ~rtc_prev_r) // [R01]
            | (apb_wr & (paddr == `FRS_OFF_SRC) & pwdata[`FRS_BIT_SWRF]); // [R14]
    end

    // Reset hold; the output is internal only, no pin is driven
    frs_stretch #(
        .CYCLES(HOLD_CYCLES)
    ) u_stretch (
        .pclk(pclk),
        .presetn(presetn),
        .trig(trig),
        .rst_out(sys_rst_out) // [R08] [R16]
    );

    // Register next values; flash error outranks software, then rtc
    always_comb begin
        lock_nxt = lock_r;
        rtcen_nxt = rtcen_r;
        ctrl_nxt = ctrl_r;
        cause_nxt = cause_r;
        imask_nxt = imask_r;
        ist_nxt = ist_r;
        rtc_prev_nxt = rtc_ev;
        if (apb_wr) begin
            case (paddr)
                `FRS_OFF_SRC: rtcen_nxt = pwdata[`FRS_BIT_RTCEN];
                `FRS_OFF_CTRL: ctrl_nxt = pwdata[1:0];
                `FRS_OFF_IRQ_STAT: ist_nxt = ist_r & ~pwdata[2:0];
                `FRS_OFF_IRQ_MASK: imask_nxt = pwdata[2:0];
                `FRS_OFF_LOCK: lock_nxt = pwdata[ADDR_W-1:0];
                default: begin
                end
            endcase
        end
        // One cause only: a new reset replaces the previous one
        if (flash_err_ev) begin
            cause_nxt = frs_pkg::FRS_CAUSE_FLASH; // [R07] [R17]
        end else if (apb_wr && paddr == `FRS_OFF_SRC && pwdata[`FRS_BIT_SWRF]) begin
            cause_nxt = frs_pkg::FRS_CAUSE_SW; // [R15] [R17]
        end else if (rtc_ev && !rtc_prev_r) begin
            cause_nxt = frs_pkg::FRS_CAUSE_RTC; // [R17]
        end
        // Sticky status: set wins over a clear in the same cycle
        ist_nxt[0] = ist_nxt[0] | flash_err_ev;
        ist_nxt[1] = ist_nxt[1] | (rtc_ev & ~rtc_prev_r);
        ist_nxt[2] = ist_nxt[2] | (apb_wr & (paddr == `FRS_OFF_SRC) & pwdata[`FRS_BIT_SWRF]);
    end

    // Read mux and address decode
    always_comb begin
        mapped = (paddr == `FRS_OFF_SRC) || (paddr == `FRS_OFF_CTRL)
            || (paddr == `FRS_OFF_IRQ_STAT) || (paddr == `FRS_OFF_IRQ_MASK)
            || (paddr == `FRS_OFF_LOCK);
        rd_nxt = `FRS_ZERO32;
        err_nxt = psel & ~penable & ~mapped;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                `FRS_OFF_SRC: begin
                    rd_nxt[`FRS_BIT_RTCEN] = rtcen_r;
                    rd_nxt[`FRS_BIT_FERR] = (cause_r == frs_pkg::FRS_CAUSE_FLASH);
                    rd_nxt[`FRS_BIT_RTC] = (cause_r == frs_pkg::FRS_CAUSE_RTC);
                    rd_nxt[`FRS_BIT_SWRF] = (cause_r == frs_pkg::FRS_CAUSE_SW);
                end
                `FRS_OFF_CTRL: rd_nxt[1:0] = ctrl_r;
                `FRS_OFF_IRQ_STAT: rd_nxt[2:0] = ist_r;
                `FRS_OFF_IRQ_MASK: rd_nxt[2:0] = imask_r;
                `FRS_OFF_LOCK: rd_nxt[ADDR_W-1:0] = lock_r;
                default: rd_nxt = `FRS_ZERO32;
            endcase
        end else if (apb_rd) begin
            rd_nxt = prdata;
        end
        if (psel && penable) begin
            err_nxt = pslverr;
        end
    end

    // Always ready: zero wait states
    assign pready = 1'b1;
    assign irq = |(ist_r & imask_r);

    // Cause flags are kept on the block's own reset only, so they survive
    // the internal reset that they describe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_r <= `FRS_LOCK_RST;
            rtcen_r <= 1'b0;
            ctrl_r <= 2'b00;
            cause_r <= frs_pkg::FRS_CAUSE_NONE;
            ist_r <= 3'b000;
            imask_r <= 3'b000;
            prdata <= `FRS_ZERO32;
            pslverr <= 1'b0;
            rtc_prev_r <= 1'b0;
        end else begin
            lock_r <= lock_nxt;
            rtcen_r <= rtcen_nxt;
            ctrl_r <= ctrl_nxt;
            cause_r <= cause_nxt;
            ist_r <= ist_nxt;
            imask_r <= imask_nxt;
            prdata <= rd_nxt;
            pslverr <= err_nxt;
            rtc_prev_r <= rtc_prev_nxt;
        end
    end
endmodule

// >>> frs_top_asserts.sv
/*
 Checker for the reset-source block: watches only frs_top ports.
 Assumes the lock address keeps its reset value during the run.
*/
`timescale 1ns/1ns
`include "frs_defs.svh"
module frs_top_asserts #(
    parameter int ADDR_W = 17,
    parameter int HOLD_CYCLES = `FRS_RST_CYCLES
) (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [11:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic flash_write_enable, // Program enable
    input wire logic external_data_move, // Data-move write
    input wire logic code_memory_read, // Code read
    input wire logic fetch_strobe, // Fetch
    input wire logic erase_strobe, // Erase
    input wire logic [ADDR_W-1:0] flash_addr, // Strobe target
    input wire logic security_block, // Security refusal
    input wire logic vdd_monitor_en, // Supply monitor on
    input wire logic sys_rst_out, // Internal reset
    input wire logic irq // Interrupt
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic oob;
    logic any_stb;
    int run_r;
    // Lock address is assumed unchanged, so its reset value is the limit
    assign oob = flash_addr > ADDR_W'(`FRS_LOCK_RST);
    // A data-move write is a flash access only with the program enable set
    assign any_stb = (flash_write_enable & external_data_move) | code_memory_read
        | fetch_strobe | erase_strobe;
    // Length of the current reset pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_r <= 0;
        end else begin
            run_r <= sys_rst_out ? run_r + 1 : 0;
        end
    end
    chk_dmove_above: assert property (flash_write_enable && external_data_move && oob |-> ##2 sys_rst_out)
        else $error("data-move write above lock gave no reset");
    chk_read_above: assert property (code_memory_read && oob |-> ##2 sys_rst_out)
        else $error("code read above lock gave no reset");
    chk_fetch_above: assert property (fetch_strobe && oob |-> ##2 sys_rst_out)
        else $error("fetch above lock gave no reset");
    chk_secure_block: assert property (security_block && any_stb |-> ##2 sys_rst_out)
        else $error("refused access gave no reset");
    chk_vdd_off: assert property ((erase_strobe || flash_write_enable && external_data_move)
        && !vdd_monitor_en |-> ##2 sys_rst_out)
        else $error("write with monitor off gave no reset");
    chk_sw_force: assert property (psel && penable && pwrite && paddr == 12'h000 && pwdata[4]
        |-> ##2 sys_rst_out)
        else $error("software force gave no reset");
    chk_hold_len: assert property ($fell(sys_rst_out) && run_r != 0 |-> run_r >= HOLD_CYCLES)
        else $error("reset pulse too short");
    chk_unmapped_err: assert property (psel && penable && paddr > 12'h010 |-> pslverr && pready)
        else $error("unmapped access not refused");
    cover property ($rose(sys_rst_out));
    cover property (psel && penable && pslverr);
    cover property ($rose(irq));
endmodule

// >>> frs_cpu_model.sv
/*
 Model of the CPU, flash controller and rtc facing the reset block.
 Assumes the bench calls its tasks right after a rising edge.
*/
`timescale 1ns/1ns
module frs_cpu_model (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    output logic external_data_move, // Data-move write strobe
    output logic code_memory_read, // Code read strobe
    output logic fetch_strobe, // Fetch strobe
    output logic erase_strobe, // Erase strobe
    output logic [16:0] flash_addr, // Target, scrambled when idle
    output logic rtc_osc_slow, // Oscillator fail level
    output logic [31:0] rtc_timer, // Rtc count
    output logic [31:0] alarm_match_registers // Alarm compare
);
    initial begin
        {external_data_move, code_memory_read, fetch_strobe, erase_strobe} = 4'h0;
        flash_addr = 17'h0_0000;
        rtc_osc_slow = 1'b0;
        alarm_match_registers = 32'hFFFF_FFFF;
    end
    // Rtc counts on every rising pclk edge and is cleared by presetn; no core sleep states are modelled
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rtc_timer <= 32'h0000_0000;
        end else begin
            rtc_timer <= rtc_timer + 32'h0000_0001;
        end
    end
    // One-cycle strobe; address scrambled afterwards so stale values are never trusted
    task automatic pulse(input logic [1:0] k, input logic [16:0] a);
        @(posedge pclk);
        {external_data_move, code_memory_read, fetch_strobe, erase_strobe} <= 4'b1000 >> k;
        flash_addr <= a;
        @(posedge pclk);
        {external_data_move, code_memory_read, fetch_strobe, erase_strobe} <= 4'h0;
        flash_addr <= ~a;
    endtask
    task automatic osc(input logic v);
        rtc_osc_slow <= v;
    endtask
    task automatic set_alarm(input logic [31:0] d);
        alarm_match_registers <= rtc_timer + d;
    endtask
endmodule

// >>> frs_top_tb.sv
/*
 Self-checking bench of frs_top with the CPU/rtc model.
 Assumes frs_defs.svh on the include path; short hold count for speed.
*/
`timescale 1ns/1ns
`include "frs_defs.svh"
bind frs_top frs_top_asserts #(.ADDR_W(ADDR_W), .HOLD_CYCLES(HOLD_CYCLES)) chk_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .flash_write_enable(flash_write_enable), .external_data_move(external_data_move),
    .code_memory_read(code_memory_read), .fetch_strobe(fetch_strobe),
    .erase_strobe(erase_strobe), .flash_addr(flash_addr), .security_block(security_block),
    .vdd_monitor_en(vdd_monitor_en), .sys_rst_out(sys_rst_out), .irq(irq));
module frs_top_tb;
    localparam int HOLD = 4;
    typedef struct packed {logic [1:0] k; logic fwe, sec, vdd, exp; logic [16:0] a;} frs_row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fwe, sec, vdd, rst, irq, e, seen;
    logic edm, cmr, fst, ers, osc;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, tmr, alm;
    logic [16:0] fa;
    int num_errors = 0;
    int check_count = 0;
    int cyc = 0;
    int n;
    logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0001_FBFF, 32'h0};
    frs_row_t rows [11] = '{
        '{2'd0, 1'b1, 1'b0, 1'b1, 1'b1, 17'h1_FFFF}, '{2'd0, 1'b0, 1'b0, 1'b1, 1'b0, 17'h1_FFFF},
        '{2'd0, 1'b1, 1'b0, 1'b1, 1'b0, 17'h1_FBFF}, '{2'd1, 1'b0, 1'b0, 1'b1, 1'b1, 17'h1_FC00},
        '{2'd1, 1'b0, 1'b0, 1'b1, 1'b0, 17'h1_FBFF}, '{2'd2, 1'b0, 1'b0, 1'b1, 1'b1, 17'h1_FC00},
        '{2'd2, 1'b0, 1'b0, 1'b1, 1'b0, 17'h0_0000}, '{2'd1, 1'b0, 1'b1, 1'b1, 1'b1, 17'h0_0010},
        '{2'd3, 1'b0, 1'b0, 1'b0, 1'b1, 17'h0_0010}, '{2'd3, 1'b0, 1'b0, 1'b1, 1'b0, 17'h0_0010},
        '{2'd0, 1'b1, 1'b0, 1'b0, 1'b1, 17'h0_0010}};
    frs_top #(.HOLD_CYCLES(HOLD)) frs_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .flash_write_enable(fwe), .external_data_move(edm),
        .code_memory_read(cmr), .fetch_strobe(fst), .erase_strobe(ers), .flash_addr(fa),
        .security_block(sec), .vdd_monitor_en(vdd), .rtc_osc_slow(osc), .rtc_timer(tmr),
        .alarm_match_registers(alm), .sys_rst_out(rst), .irq(irq));
    frs_cpu_model frs_cpu_model_inst (.pclk(pclk), .presetn(presetn), .external_data_move(edm),
        .code_memory_read(cmr), .fetch_strobe(fst), .erase_strobe(ers), .flash_addr(fa),
        .rtc_osc_slow(osc), .rtc_timer(tmr), .alarm_match_registers(alm));
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // Cuts a hang short; ceiling well above the planned run
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            conclude();
        end
    end
    task automatic conclude();
        if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Setup then access; held until pready seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wait_rst(input int cnt);
        seen = 1'b0;
        repeat (cnt) begin
            @(posedge pclk);
            if (rst === 1'b1) seen = 1'b1;
        end
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, fwe, sec, vdd} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, last row is unmapped and must be refused
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0);
            chk(q, rv[i]);
            chk(e, i == 5);
        end
        apb(1'b1, `FRS_OFF_IRQ_MASK, 32'h0000_0007);
        // Flash error cases
        foreach (rows[i]) begin
            {fwe, sec, vdd} <= {rows[i].fwe, rows[i].sec, rows[i].vdd};
            frs_cpu_model_inst.pulse(rows[i].k, rows[i].a);
            @(posedge pclk);
            #1 chk(rst, rows[i].exp);
            repeat (HOLD + 1) @(posedge pclk);
            {fwe, sec, vdd} <= 3'b001;
            apb(1'b0, `FRS_OFF_SRC, 32'h0);
            if (rows[i].exp) chk(q[6:4], 3'b100);
            chk(irq, rows[i].exp);
            apb(1'b1, `FRS_OFF_IRQ_STAT, 32'h0000_0007);
        end
        // Software force: pulse length, cause flag, masked and unmasked interrupt
        apb(1'b1, `FRS_OFF_SRC, 32'h0000_0010);
        n = 0;
        repeat (3 * HOLD) begin
            #1 n += rst;
            @(posedge pclk);
        end
        chk(n, HOLD);
        apb(1'b0, `FRS_OFF_SRC, 32'h0);
        chk(q, 32'h0000_0010);
        chk(irq, 1'b1);
        apb(1'b1, `FRS_OFF_IRQ_MASK, 32'h0);
        #1 chk(irq, 1'b0);
        apb(1'b1, `FRS_OFF_IRQ_STAT, 32'h0000_0007);
        apb(1'b0, `FRS_OFF_IRQ_STAT, 32'h0);
        chk(q, 32'h0);
        // Rtc: no reset while its enable is off, then fail and alarm both reset
        apb(1'b1, `FRS_OFF_CTRL, 32'h0000_0003);
        frs_cpu_model_inst.osc(1'b1);
        wait_rst(12);
        chk(seen, 1'b0);
        frs_cpu_model_inst.osc(1'b0);
        apb(1'b1, `FRS_OFF_SRC, 32'h0000_0080);
        frs_cpu_model_inst.osc(1'b1);
        wait_rst(12);
        chk(seen, 1'b1);
        apb(1'b0, `FRS_OFF_SRC, 32'h0);
        chk(q, 32'h0000_00A0);
        frs_cpu_model_inst.osc(1'b0);
        wait_rst(HOLD + 4);
        frs_cpu_model_inst.set_alarm(32'd30);
        wait_rst(40);
        chk(seen, 1'b1);
        // Block reset in mid-pulse: the held reset ends and the causes clear
        apb(1'b1, `FRS_OFF_SRC, 32'h0000_0010);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        #1 chk(rst, 1'b0);
        chk(irq, 1'b0);
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `FRS_OFF_SRC, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, `FRS_OFF_LOCK, 32'h0);
        chk(q, 32'h0001_FBFF);
        conclude();
    end
endmodule
